// *** verilog/fabric_loader_consts.vh ***
// constants for the fabric configuration loader
`ifndef FABRIC_LOADER_CONSTS_VH
`define FABRIC_LOADER_CONSTS_VH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_CREDIT 8'h08
`define REG_DATA 8'h0C
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_START 0
`define CTRL_UPDATE 1
`define CTRL_TEARDOWN 2
`define ST_ERROR 0
`define ST_FABRIC_DONE 1
`define ST_PERIPH_DONE 2
`define ST_BUSY 3
`define ST_DEAD 4
`define ST_REFCLK_OK 5
`define ST_UPDATE 6
// ----------------------------------------------------------------
// reset values and image layout
// ----------------------------------------------------------------
`define CREDIT_RESET 8'h00
`define BLOCK_WORDS 11'h400
`define EARLY_LIMIT_KB 168
`define EARLY_LIMIT_WORDS (`EARLY_LIMIT_KB * 1024 / 4)
// arbitrary tool version code expected in the image header
`define TOOL_VERSION 16'h5A3C
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ 250
`define GRANT_WINDOW_MS 50
`define GRANT_WINDOW_CYC (`GRANT_WINDOW_MS * 1000 * `CLK_MHZ)
`define REFCLK_LOSS_CYC 8'h40
`define GEN_MIN 2'h1
`define GEN_MAX 2'h3
`endif

// *** verilog/image_checker.v ***
// block checksum, header and length tracking for a streamed fabric image
`timescale 1ns/1ps
`include "fabric_loader_consts.vh"
module image_checker
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire clear_i,
  input wire word_valid_i,
  input wire [31:0] word_i,
  output reg block_done_o,
  output reg image_done_o,
  output reg corrupt_o,
  output reg version_bad_o,
  output reg [31:0] word_count_o
);
  // ----------------------------------------------------------------
  // image layout: word 0 carries the tool version in its upper half,
  // word 1 the length in 4KB blocks; the last word of each block is
  // the xor of the other words of that block
  // ----------------------------------------------------------------
  reg [10:0] idx_q;
  reg [31:0] sum_q;
  reg [15:0] blocks_q;
  reg [15:0] total_q;
  wire last_word;
  assign last_word = (idx_q == (`BLOCK_WORDS - 11'h001));

  always @(posedge sys_clk_i)
  begin
    if (reset_i || clear_i)
    begin
      idx_q <= 11'h000;
      sum_q <= 32'h00000000;
      blocks_q <= 16'h0000;
      total_q <= 16'h0000;
      block_done_o <= 1'b0;
      image_done_o <= 1'b0;
      corrupt_o <= 1'b0;
      version_bad_o <= 1'b0;
      word_count_o <= 32'h00000000;
    end
    else
    begin
      block_done_o <= 1'b0;
      image_done_o <= 1'b0;
      corrupt_o <= 1'b0;
      version_bad_o <= 1'b0;
      if (word_valid_i)
      begin
        word_count_o <= word_count_o + 32'h00000001;
        if (word_count_o == 32'h00000000 && word_i[31:16] != `TOOL_VERSION)
          version_bad_o <= 1'b1;
        if (word_count_o == 32'h00000001)
          total_q <= word_i[15:0];
        if (last_word)
        begin
          idx_q <= 11'h000;
          sum_q <= 32'h00000000;
          blocks_q <= blocks_q + 16'h0001;
          if (word_i != sum_q)
            corrupt_o <= 1'b1;
          else if (blocks_q + 16'h0001 >= total_q)
            image_done_o <= 1'b1;
          else
            block_done_o <= 1'b1;
        end
        else
        begin
          idx_q <= idx_q + 11'h001;
          sum_q <= sum_q ^ word_i;
        end
      end
    end
  end
endmodule // image_checker

// *** verilog/fabric_config_loader.v ***
// fabric configuration loader behind a pcie endpoint
// Operation
// [R1] image data is taken only from memory writes, config writes are dropped
// [R2] next 4KB block must arrive within 50 ms of a credit, else fail
// [R3] host tolerates variable response time, typically 5 s, up to 1 min
// [R4] host times out by polling the credit register status
// [R5] fabric-dependent functions stay inaccessible while fabric is unprogrammed
// [R6] corruption within first 168KB raises error flag, recoverable
// [R7] host performs teardown after recoverable error before a new image
// [R8] corruption after 168KB raises error flag, only power cycle recovers
// [R9] image from a different tool version raises error flag
// [R10] bus error during loading locks the loader until power cycle
// [R11] fundamental reset asserted during loading locks until power cycle
// [R12] host never aborts a requested load
// [R13] update mode reconfigures all but the loading pcie core
// [R14] update images keep periphery unchanged
// [R15] link keeps serving application traffic during update
// [R16] init mode brings periphery from flash first, then fabric over link
// [R17] loading works at link generations 1, 2 and 3
// [R18] only the bottom-left endpoint hard core may carry loading
// [R19] host supplies a running reference clock before configuration
// [R20] fabric load done low while loading, high on success
// [R21] periphery done goes high once periphery image is loaded
// [R22] host stops writing image data once error flag is seen
`timescale 1ns/1ps
`include "fabric_loader_consts.vh"
module fabric_config_loader
#(
  parameter GRANT_WINDOW_CYCLES = `GRANT_WINDOW_CYC
)
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_memwr_i,
  output reg [31:0] reg_rdata_o,
  input wire link_refclk_i,
  input wire perst_n_i,
  input wire flash_periph_done_i,
  input wire flash_full_image_i,
  input wire bus_error_i,
  input wire [1:0] link_gen_i,
  input wire hip_bl_endpoint_i,
  output reg periphery_load_done_o,
  output reg fabric_load_done_o,
  output reg fabric_access_en_o,
  output reg fabric_reset_o,
  output reg link_app_en_o
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [5:0] S_BOOT = 6'h01;
  localparam [5:0] S_IDLE = 6'h02;
  localparam [5:0] S_LOAD = 6'h04;
  localparam [5:0] S_USER = 6'h08;
  localparam [5:0] S_ERR = 6'h10;
  localparam [5:0] S_DEAD = 6'h20;

  function sel;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers: refclk, perst_n, flash done
  // ----------------------------------------------------------------
  wire [2:0] pin_raw;
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;
  assign pin_raw = {flash_periph_done_i, perst_n_i, link_refclk_i};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
      always @(posedge sys_clk_i)
      begin
        if (reset_i)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  wire refclk_s = sync2_q[0];
  wire perst_ok = sync2_q[1];
  wire flash_done_s = sync2_q[2];

  // ----------------------------------------------------------------
  // reference clock activity watch
  // ----------------------------------------------------------------
  reg refclk_d_q;
  reg [7:0] refclk_idle_q;
  wire refclk_ok = (refclk_idle_q < `REFCLK_LOSS_CYC);
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      refclk_d_q <= 1'b0;
      refclk_idle_q <= `REFCLK_LOSS_CYC;
    end
    else
    begin
      refclk_d_q <= refclk_s;
      if (refclk_s != refclk_d_q)
        refclk_idle_q <= 8'h00;
      else if (!refclk_ok)
        refclk_idle_q <= refclk_idle_q;
      else
        refclk_idle_q <= refclk_idle_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr_i && sel(reg_addr_i, `REG_CTRL);
  wire cmd_start = wr_ctrl && reg_wdata_i[`CTRL_START];
  wire cmd_update = reg_wdata_i[`CTRL_UPDATE];
  wire cmd_teardown = wr_ctrl && reg_wdata_i[`CTRL_TEARDOWN];
  reg [5:0] state_q;
  // data register only counts on a memory write during a load
  wire data_wr = reg_wr_i && reg_memwr_i && sel(reg_addr_i, `REG_DATA) && (state_q == S_LOAD); // [R1]
  wire gen_ok = (link_gen_i >= `GEN_MIN) && (link_gen_i <= `GEN_MAX); // [R17]
  wire start_ok = refclk_ok && perst_ok && gen_ok && hip_bl_endpoint_i; // [R18]
  // init only from an unprogrammed fabric, update only from user mode
  wire start_fire = cmd_start && start_ok && ((state_q == S_IDLE && !cmd_update) ||
    (state_q == S_USER && cmd_update)); // [R13]

  // ----------------------------------------------------------------
  // image checker
  // ----------------------------------------------------------------
  wire blk_done;
  wire img_done;
  wire corrupt;
  wire version_bad;
  wire [31:0] word_count;
  image_checker u_check
  (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .clear_i(start_fire),
    .word_valid_i(data_wr),
    .word_i(reg_wdata_i),
    .block_done_o(blk_done),
    .image_done_o(img_done),
    .corrupt_o(corrupt),
    .version_bad_o(version_bad),
    .word_count_o(word_count)
  );
  wire early = (word_count <= `EARLY_LIMIT_WORDS);

  // ----------------------------------------------------------------
  // load sequencer
  // ----------------------------------------------------------------
  reg [7:0] credit_q;
  reg [31:0] timer_q;
  reg waiting_q;
  reg error_q;
  reg update_q;
  wire timeout = waiting_q && (timer_q == 32'h00000000);
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      state_q <= S_BOOT;
      credit_q <= `CREDIT_RESET;
      timer_q <= 32'h00000000;
      waiting_q <= 1'b0;
      error_q <= 1'b0;
      update_q <= 1'b0;
    end
    else
    begin
      if (waiting_q && timer_q != 32'h00000000)
        timer_q <= timer_q - 32'h00000001;
      case (state_q)
        S_BOOT:
        begin
          // periphery comes from flash before the link may load fabric
          if (flash_done_s) // [R16]
            state_q <= flash_full_image_i ? S_USER : S_IDLE;
        end
        S_IDLE, S_USER:
        begin
          // the checker is cleared by the same strobe, so a word right after it counts
          if (start_fire) // [R13]
          begin
            state_q <= S_LOAD;
            update_q <= cmd_update;
            credit_q <= credit_q + 8'h01;
            waiting_q <= 1'b1;
            timer_q <= GRANT_WINDOW_CYCLES[31:0];
          end
        end
        S_LOAD:
        begin
          if (bus_error_i || !perst_ok) // [R10] [R11]
          begin
            state_q <= S_DEAD;
            error_q <= 1'b1;
          end
          else if (corrupt || timeout) // [R2]
          begin
            state_q <= early ? S_ERR : S_DEAD; // [R6] [R8]
            error_q <= 1'b1;
          end
          else if (version_bad) // [R9]
          begin
            state_q <= S_ERR;
            error_q <= 1'b1;
          end
          else if (img_done)
          begin
            state_q <= S_USER;
            waiting_q <= 1'b0;
          end
          else if (blk_done)
          begin
            // grant one more block and restart the delivery window
            credit_q <= credit_q + 8'h01;
            waiting_q <= 1'b1;
            timer_q <= GRANT_WINDOW_CYCLES[31:0]; // [R2]
          end
          else if (data_wr)
            waiting_q <= 1'b0;
        end
        S_ERR:
        begin
          waiting_q <= 1'b0;
          // teardown brings back an unprogrammed fabric ready for a new image
          if (cmd_teardown)
          begin
            state_q <= S_IDLE;
            error_q <= 1'b0;
          end
        end
        S_DEAD:
        begin
          // no way out but a power cycle
          waiting_q <= 1'b0;
          error_q <= 1'b1;
        end
        default:
          state_q <= S_DEAD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      periphery_load_done_o <= 1'b0;
      fabric_load_done_o <= 1'b0;
      fabric_access_en_o <= 1'b0;
      fabric_reset_o <= 1'b1;
      link_app_en_o <= 1'b0;
    end
    else
    begin
      if (state_q != S_BOOT)
        periphery_load_done_o <= 1'b1; // [R21]
      fabric_load_done_o <= (state_q == S_USER); // [R20]
      fabric_access_en_o <= (state_q == S_USER); // [R5]
      // only fabric is held in reset, the loading core keeps running
      fabric_reset_o <= (state_q != S_USER); // [R13]
      link_app_en_o <= (state_q != S_BOOT) && (state_q != S_DEAD) && perst_ok; // [R15]
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  always @*
  begin
    rd_mux = 32'h00000000;
    if (sel(reg_addr_i, `REG_STATUS))
    begin
      rd_mux[`ST_ERROR] = error_q;
      rd_mux[`ST_FABRIC_DONE] = fabric_load_done_o;
      rd_mux[`ST_PERIPH_DONE] = periphery_load_done_o;
      rd_mux[`ST_BUSY] = (state_q == S_LOAD);
      rd_mux[`ST_DEAD] = (state_q == S_DEAD);
      rd_mux[`ST_REFCLK_OK] = refclk_ok;
      rd_mux[`ST_UPDATE] = update_q;
    end
    else if (sel(reg_addr_i, `REG_CREDIT))
    begin
      rd_mux[7:0] = credit_q;
      rd_mux[8 + `ST_ERROR] = error_q;
    end
  end
  always @(posedge sys_clk_i)
  begin
    if (reset_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
      reg_rdata_o <= rd_mux;
    else
      reg_rdata_o <= 32'h00000000;
  end
endmodule // fabric_config_loader

// *** verif/fabric_loader_monitor.sv ***
// port-level assertion checker for the fabric configuration loader
`timescale 1ns/1ps
`include "fabric_loader_consts.vh"
module fabric_loader_monitor
#(
  parameter GRANT_WINDOW_CYCLES = 2000
)
(
  input wire sys_clk_i,
  input wire reset_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire reg_memwr_i,
  input wire [31:0] reg_rdata_o,
  input wire flash_periph_done_i,
  input wire flash_full_image_i,
  input wire periphery_load_done_o,
  input wire fabric_load_done_o,
  input wire fabric_access_en_o,
  input wire fabric_reset_o,
  input wire link_app_en_o
);
  wire ctrl_wr;
  wire data_wr;
  assign ctrl_wr = reg_wr_i && (reg_addr_i == `REG_CTRL);
  assign data_wr = reg_wr_i && reg_memwr_i && (reg_addr_i == `REG_DATA);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // a control write takes two cycles to reach the outputs
  sequence s_ctrl_quiet;
    !ctrl_wr ##1 !ctrl_wr;
  endsequence
  sequence s_word_landed;
    $past(data_wr, 3);
  endsequence
  a_access_tracks_done: assert property (fabric_access_en_o == fabric_load_done_o)
    else $error("fabric access differs from load done");
  a_reset_unprogrammed: assert property (!fabric_load_done_o |-> fabric_reset_o)
    else $error("fabric out of reset while unprogrammed");
  a_app_after_periph: assert property (link_app_en_o |-> periphery_load_done_o)
    else $error("link serves before periphery is loaded");
  a_periph_sticky: assert property (periphery_load_done_o |=> periphery_load_done_o)
    else $error("periphery done dropped");
  a_periph_after_flash: assert property ($rose(periphery_load_done_o) |-> $past(flash_periph_done_i, 2))
    else $error("periphery done without flash load");
  a_done_after_word: assert property ($rose(fabric_load_done_o) && !flash_full_image_i |-> s_word_landed)
    else $error("load done not three cycles after an image word");
  a_done_holds: assert property (s_ctrl_quiet ##0 fabric_load_done_o |=> fabric_load_done_o)
    else $error("load done dropped without a control write");
  a_app_in_update: assert property ($fell(fabric_load_done_o) |-> link_app_en_o)
    else $error("link stopped when an update began");
  a_rdata_one_cycle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h00000000)
    else $error("read data outside its cycle");
endmodule // fabric_loader_monitor

// *** verif/pcie_host_env.sv ***
// board model: reference clock, fundamental reset and flash periphery load
`timescale 1ns/1ps
module pcie_host_env
#(
  parameter FLASH_CYCLES = 20
)
(
  input wire sys_clk_i,
  input wire power_on_i,
  input wire perst_req_i,
  output reg link_refclk_o,
  output reg perst_n_o,
  output reg flash_periph_done_o
);
  integer cnt_q = 0;
  initial
  begin
    link_refclk_o = 1'b0;
    perst_n_o = 1'b0;
    flash_periph_done_o = 1'b0;
  end
  // reference clock runs free whenever the board has power
  always #40 link_refclk_o = power_on_i ? ~link_refclk_o : 1'b0;
  always @(posedge sys_clk_i)
  begin
    perst_n_o <= power_on_i && !perst_req_i;
    cnt_q <= power_on_i ? cnt_q + 1 : 0;
    // flash load takes a while, so the periphery comes up late
    flash_periph_done_o <= power_on_i && (cnt_q >= FLASH_CYCLES);
  end
endmodule // pcie_host_env

// *** verif/tb_top.sv ***
// self-checking bench for the fabric configuration loader
`timescale 1ns/1ps
`include "fabric_loader_consts.vh"
module tb_top;
  localparam GW = 2000;
  reg sys_clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  reg reg_memwr_i = 1'b0;
  reg bus_error_i = 1'b0;
  reg [1:0] link_gen_i = 2'h0;
  reg hip_bl_endpoint_i = 1'b0;
  reg flash_full_image_i = 1'b0;
  reg power_on = 1'b0;
  reg perst_req = 1'b0;
  wire [31:0] reg_rdata_o;
  wire link_refclk_i, perst_n_i, flash_periph_done_i;
  wire periphery_load_done_o, fabric_load_done_o, fabric_access_en_o;
  wire fabric_reset_o, link_app_en_o;
  integer n_fail = 0;
  integer tests_run = 0;
  integer g;
  integer cr;
  always #2 sys_clk_i = ~sys_clk_i;
  pcie_host_env u_pcie_host_env (.sys_clk_i(sys_clk_i), .power_on_i(power_on),
    .perst_req_i(perst_req), .link_refclk_o(link_refclk_i), .perst_n_o(perst_n_i),
    .flash_periph_done_o(flash_periph_done_i));
  fabric_config_loader #(.GRANT_WINDOW_CYCLES(GW)) u_fabric_config_loader (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_memwr_i(reg_memwr_i), .reg_rdata_o(reg_rdata_o), .link_refclk_i(link_refclk_i),
    .perst_n_i(perst_n_i), .flash_periph_done_i(flash_periph_done_i),
    .flash_full_image_i(flash_full_image_i), .bus_error_i(bus_error_i),
    .link_gen_i(link_gen_i),
    .hip_bl_endpoint_i(hip_bl_endpoint_i), .periphery_load_done_o(periphery_load_done_o),
    .fabric_load_done_o(fabric_load_done_o), .fabric_access_en_o(fabric_access_en_o),
    .fabric_reset_o(fabric_reset_o), .link_app_en_o(link_app_en_o));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [31:0] d, input m);
  begin
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_memwr_i <= m;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] mask, input [31:0] exp);
  begin
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o & mask, exp);
  end
  endtask
  // header word, block count, then xor-closed blocks; block bad gets a wrong check word
  task send_image(input integer nblk, input integer nw, input integer bad, input [15:0] ver);
    integer n;
    reg [31:0] w, x;
  begin
    @(posedge sys_clk_i);
    reg_addr_i <= `REG_DATA;
    reg_memwr_i <= 1'b1;
    reg_wr_i <= 1'b1;
    x = 32'h0;
    for (n = 0; n < nw; n = n + 1)
    begin
      if (n % 1024 == 1023)
        w = x ^ {31'h0, n / 1024 == bad};
      else if (n == 0)
        w = {ver, 16'h0000};
      else if (n == 1)
        w = nblk;
      else
        w = n;
      x = (n % 1024 == 1023) ? 32'h0 : x ^ w;
      reg_wdata_i <= w;
      @(posedge sys_clk_i);
    end
    reg_wr_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  end
  endtask
  task power_cycle;
  begin
    reset_i <= 1'b1;
    power_on <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk({periphery_load_done_o, link_app_en_o, fabric_reset_o, fabric_load_done_o}, 4'h2);
    @(posedge sys_clk_i);
    reset_i <= 1'b0;
    power_on <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    #1;
    chk({periphery_load_done_o, link_app_en_o}, 2'h3);
    cr = 0;
  end
  endtask
  task report_and_stop;
  begin
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    power_cycle;
    rd(`REG_CREDIT, 32'h1FF, 32'h0);
    rd(8'h10, 32'hFFFFFFFF, 32'h0);
    hip_bl_endpoint_i <= 1'b1;
    wr(`REG_CTRL, 32'h1, 1'b1);
    rd(`REG_STATUS, 32'h8, 32'h0);
    link_gen_i <= 2'h1;
    hip_bl_endpoint_i <= 1'b0;
    wr(`REG_CTRL, 32'h1, 1'b1);
    rd(`REG_STATUS, 32'h8, 32'h0);
    hip_bl_endpoint_i <= 1'b1;
    for (g = 1; g < 4; g = g + 1)
    begin
      link_gen_i <= g[1:0];
      wr(`REG_CTRL, (g == 1) ? 32'h1 : 32'h3, 1'b1);
      cr = cr + 1;
      rd(`REG_STATUS, 32'h7F, (g == 1) ? 32'h2C : 32'h6C);
      chk(link_app_en_o, 1'b1);
      wr(`REG_DATA, 32'hFFFFFFFF, 1'b0);
      send_image(1, 1024, 9, `TOOL_VERSION);
      rd(`REG_STATUS, 32'h7F, (g == 1) ? 32'h26 : 32'h66);
      rd(`REG_CREDIT, 32'h1FF, cr);
    end
    wr(`REG_CTRL, 32'h3, 1'b1);
    cr = cr + 1;
    send_image(1, 2, 9, ~`TOOL_VERSION);
    rd(`REG_STATUS, 32'h7F, 32'h65);
    rd(`REG_CREDIT, 32'h1FF, 32'h100 | cr);
    wr(`REG_CTRL, 32'h4, 1'b1);
    rd(`REG_STATUS, 32'h3F, 32'h24);
    chk({fabric_access_en_o, fabric_reset_o}, 2'h1);
    wr(`REG_CTRL, 32'h1, 1'b1);
    send_image(1, 1024, 0, `TOOL_VERSION);
    rd(`REG_STATUS, 32'h3F, 32'h25);
    wr(`REG_CTRL, 32'h4, 1'b1);
    rd(`REG_STATUS, 32'h3F, 32'h24);
    wr(`REG_CTRL, 32'h1, 1'b1);
    repeat (GW - 50) @(posedge sys_clk_i);
    rd(`REG_STATUS, 32'h3F, 32'h2C);
    repeat (100) @(posedge sys_clk_i);
    rd(`REG_STATUS, 32'h3F, 32'h25);
    wr(`REG_CTRL, 32'h4, 1'b1);
    wr(`REG_CTRL, 32'h1, 1'b1);
    send_image(43, 43 * 1024, 42, `TOOL_VERSION);
    rd(`REG_STATUS, 32'h3F, 32'h35);
    wr(`REG_CTRL, 32'h4, 1'b1);
    rd(`REG_STATUS, 32'h3F, 32'h35);
    power_cycle;
    wr(`REG_CTRL, 32'h1, 1'b1);
    send_image(1, 10, 9, `TOOL_VERSION);
    bus_error_i <= 1'b1;
    @(posedge sys_clk_i);
    bus_error_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rd(`REG_STATUS, 32'h10, 32'h10);
    chk(link_app_en_o, 1'b0);
    flash_full_image_i <= 1'b1;
    power_cycle;
    chk(fabric_load_done_o, 1'b1);
    wr(`REG_CTRL, 32'h3, 1'b1);
    perst_req <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    perst_req <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rd(`REG_STATUS, 32'h10, 32'h10);
    report_and_stop;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk_i);
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule // tb_top
bind fabric_config_loader fabric_loader_monitor
  #(.GRANT_WINDOW_CYCLES(GRANT_WINDOW_CYCLES)) u_fabric_loader_monitor (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_memwr_i(reg_memwr_i), .reg_rdata_o(reg_rdata_o),
  .flash_periph_done_i(flash_periph_done_i), .flash_full_image_i(flash_full_image_i),
  .periphery_load_done_o(periphery_load_done_o), .fabric_load_done_o(fabric_load_done_o),
  .fabric_access_en_o(fabric_access_en_o), .fabric_reset_o(fabric_reset_o),
  .link_app_en_o(link_app_en_o));
